// >>> verilog/tso_out_port.sv
// transport stream output port: byte fifo, serial/parallel framer, output clock,
// sync lock counter and its configuration registers.
// assumes upstream decoder logic on the same master clock delivers bytes with flags.
`include "tso_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - data-valid stays low whenever sync lock flag is clear.
// - parallel format follows common interface stream timing: byte, strobe, valid, error.
// - output clock high time is between forty and sixty percent of period.
// - serial format shifts each byte on top data line, msb first.
// - parity blank 0 sends parity bits serially; 1 sends zeros instead.
// - serial strobe covers only first bit; parallel strobe covers first byte.
// - error output behaves the same in serial and parallel formats.
// - serial clock from master clock at 0, slower skipped-pulse clock at 1.
// - every interface output updates on one common master clock edge.
// - serial output clock keeps toggling during parity bytes.
// - serial format holds the seven lower data lines low.
// - impedance control bit floats data, clock, strobe, valid and error.
// - output type bit selects parallel byte stream or serial bit stream.
// - lock set when sync counter hits maximum, cleared at zero.
// - uncorrectable packet produces a pulse on the error output.
module tso_out_port (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// register port
	input  wire logic [7:0]       i_reg_addr,
	input  wire logic [7:0]       i_reg_wdata,
	input  wire logic             i_reg_wr,
	output logic [7:0]            o_reg_rdata,
	// upstream byte stream
	input  wire tso_pkg::tso_byte_t i_byte,
	input  wire logic             i_byte_valid,
	input  wire logic             i_byte_start,
	input  wire logic             i_byte_err,
	input  wire logic             i_byte_parity,
	output logic                  o_byte_ready,
	// sync word events
	input  wire logic             i_sync_found,
	input  wire logic             i_sync_missed,
	input  wire logic [7:0]       i_sync_max,
	// output pins
	output logic [7:0]            o_data,
	output logic                  o_clk_out,
	output logic                  o_strobe,
	output logic                  o_valid,
	output logic                  o_error,
	output logic                  o_oe,
	output logic                  o_edge_sel
);
	import tso_pkg::*;

	logic [7:0]             mclk_cfg_r;
	logic [7:0]             fec_mode_r;
	logic [7:0]             dec_ctrl_r;
	logic [7:0]             sync_cnt_r;
	logic                   lock_r;
	logic [`TSO_WORD_W-1:0] fifo_wdata;
	logic [`TSO_WORD_W-1:0] fifo_rdata;
	logic                   fifo_rvalid;
	logic                   fifo_wready;
	logic                   pop;
	logic                   src_vco;
	logic                   ser_mode;
	logic                   par_blank;
	logic                   out_imp;
	logic [1:0]             half_len;
	logic [1:0]             cnt_r;
	logic                   tick;
	tso_phase_e             phase_r;
	logic                   have_r;
	tso_byte_t              byte_r;
	logic                   start_r;
	logic                   err_r;
	logic                   par_r;
	logic [2:0]             bit_r;
	logic                   need_next;
	logic                   cur_bit;
	logic [7:0]             data_nxt;

	// control fields
	assign src_vco   = mclk_cfg_r[`TSO_BIT_SER_SRC];
	assign ser_mode  = fec_mode_r[`TSO_BIT_OUT_SER];
	assign out_imp   = fec_mode_r[`TSO_BIT_OUT_IMP];
	assign par_blank = dec_ctrl_r[`TSO_BIT_PAR_BLANK];

	// register writes; reads of write registers return the stored value
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mclk_cfg_r <= `TSO_RST_MCLK_CFG;
			fec_mode_r <= `TSO_RST_FEC_MODE;
			dec_ctrl_r <= `TSO_RST_DEC_CTRL;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`TSO_ADDR_MCLK_CFG: mclk_cfg_r <= i_reg_wdata;
				`TSO_ADDR_FEC_MODE: fec_mode_r <= i_reg_wdata;
				`TSO_ADDR_DEC_CTRL: dec_ctrl_r <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// read data, registered; unmapped offsets read zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else begin
			case (i_reg_addr)
				`TSO_ADDR_MCLK_CFG: o_reg_rdata <= mclk_cfg_r;
				`TSO_ADDR_FEC_MODE: o_reg_rdata <= fec_mode_r;
				`TSO_ADDR_DEC_CTRL: o_reg_rdata <= dec_ctrl_r;
				`TSO_ADDR_VIT_STAT: o_reg_rdata <= 8'(lock_r) << `TSO_BIT_LOCK;
				default:            o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// up/down sync counter; a found and a missed word in one cycle cancel
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync_cnt_r <= `TSO_RST_SYNC_CNT;
			lock_r     <= 1'b0;
		end else begin
			if (i_sync_found && !i_sync_missed && sync_cnt_r < i_sync_max) begin
				sync_cnt_r <= sync_cnt_r + 8'h01;
				if (sync_cnt_r + 8'h01 == i_sync_max) begin
					lock_r <= 1'b1;
				end
			end else if (i_sync_missed && !i_sync_found && sync_cnt_r != 8'h00) begin
				sync_cnt_r <= sync_cnt_r - 8'h01;
				if (sync_cnt_r == 8'h01) begin
					lock_r <= 1'b0;
				end
			end
		end
	end

	// byte fifo between decoder and framer; full stalls the decoder
	assign fifo_wdata   = {i_byte_parity, i_byte_err, i_byte_start, i_byte};
	assign o_byte_ready = fifo_wready;
	tso_fifo #(
		.W(`TSO_WORD_W),
		.D(`TSO_FIFO_DEPTH)
	) u_fifo (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_wdata  (fifo_wdata),
		.i_wvalid (i_byte_valid),
		.o_wready (fifo_wready),
		.o_rdata  (fifo_rdata),
		.o_rvalid (fifo_rvalid),
		.i_rready (pop)
	);

	// half period: one cycle from master clock, two when the slow source is chosen
	assign half_len = src_vco ? `TSO_HALF_VCO : `TSO_HALF_MCLK;
	assign tick     = (cnt_r >= half_len - 2'h1); // a source change never leaves cnt_r stranded

	// half period counter
	always_ff @(posedge i_clk) begin
		if (i_rst || tick) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
		end
	end

	// clock phase; equal high and low halves give 50 percent duty
	// slow source skips a high pulse while no byte is in hand
	// master source runs on through parity and gaps alike
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			phase_r <= PH_LOW;
		end else if (tick) begin
			case (phase_r)
				PH_LOW: begin
					if (!src_vco || have_r) begin
						phase_r <= PH_HIGH;
					end
				end
				PH_HIGH: phase_r <= PH_LOW;
				default: phase_r <= PH_LOW;
			endcase
		end
	end

	// a new byte is needed after the last serial bit, or every cycle in parallel
	assign need_next = !have_r || !ser_mode || (bit_r == `TSO_LAST_BIT);
	assign pop       = tick && need_next && fifo_rvalid && ((phase_r == PH_HIGH) || !have_r);

	// shift state, advanced at the falling half of the output clock
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			have_r  <= 1'b0;
			byte_r  <= 8'h00;
			start_r <= 1'b0;
			err_r   <= 1'b0;
			par_r   <= 1'b0;
			bit_r   <= 3'h0;
		end else if (pop) begin
			have_r  <= 1'b1;
			{par_r, err_r, start_r, byte_r} <= fifo_rdata;
			bit_r   <= 3'h0;
		end else if (tick && phase_r == PH_HIGH) begin
			if (need_next) begin
				have_r <= 1'b0;
			end else begin
				bit_r <= bit_r + 3'h1;
			end
		end
	end

	// msb first on the top line; parity optionally blanked
	assign cur_bit = byte_r[`TSO_LAST_BIT - bit_r] && !(par_r && par_blank);

	// data next value: lower lines held low in serial format
	always_comb begin
		data_nxt = 8'h00;
		if (have_r) begin
			if (ser_mode) begin
				data_nxt = {cur_bit, 7'h00};
			end else begin
				data_nxt = byte_r;
			end
		end
	end

	// all pins from flops on the same edge, one cycle behind internal state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_data    <= 8'h00;
			o_clk_out <= 1'b0;
			o_strobe  <= 1'b0;
			o_valid   <= 1'b0;
			o_error   <= 1'b0;
		end else begin
			o_data    <= data_nxt;
			o_clk_out <= (phase_r == PH_HIGH);
			o_strobe  <= have_r && start_r && (!ser_mode || bit_r == 3'h0);
			o_valid   <= have_r && lock_r;
			o_error   <= have_r && err_r;
		end
	end

	// enable low floats every stream pin; edge select tells the receiver its edge
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_oe       <= 1'b0;
			o_edge_sel <= 1'b0;
		end else begin
			o_oe       <= !out_imp;
			o_edge_sel <= dec_ctrl_r[`TSO_BIT_EDGE_SEL];
		end
	end

	// sequences for the checks below
	sequence s_mclk_high;
		$rose(o_clk_out) ##1 !o_clk_out;
	endsequence

	sequence s_serial_bit0;
		ser_mode && have_r && bit_r == 3'h0;
	endsequence

	AST_NO_VALID_UNLOCKED: assert property (@(posedge i_clk) disable iff (i_rst)
		!lock_r |=> !o_valid)
		else $error("data valid high without lock");

	AST_DUTY_MCLK: assert property (@(posedge i_clk) disable iff (i_rst)
		(!src_vco && !i_rst)[*2] ##0 $rose(o_clk_out) |-> s_mclk_high)
		else $error("output clock high time wrong");

	AST_MSB_FIRST: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_serial_bit0 and !(par_r && par_blank)) |=> o_data[7] == $past(byte_r[7]))
		else $error("serial bit not msb first");

	AST_PARITY_BLANK: assert property (@(posedge i_clk) disable iff (i_rst)
		(ser_mode && have_r && par_r && par_blank) |=> o_data == 8'h00)
		else $error("parity slot not blanked");

	AST_STROBE_FIRST_BIT: assert property (@(posedge i_clk) disable iff (i_rst)
		(ser_mode && have_r && bit_r != 3'h0) |=> !o_strobe)
		else $error("serial strobe beyond first bit");

	AST_CLK_RUNS: assert property (@(posedge i_clk) disable iff (i_rst)
		(!src_vco && !i_rst)[*3] |-> o_clk_out != $past(o_clk_out))
		else $error("output clock stalled");

	AST_LOW_LINES: assert property (@(posedge i_clk) disable iff (i_rst)
		ser_mode |=> o_data[6:0] == 7'h00)
		else $error("lower data lines active in serial");

	AST_HIGHZ: assert property (@(posedge i_clk) disable iff (i_rst)
		out_imp |=> !o_oe)
		else $error("pins driven while floating");

	AST_LOCK_SET: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_sync_found && !i_sync_missed && sync_cnt_r + 8'h01 == i_sync_max) |=> lock_r)
		else $error("lock not set at maximum");

	AST_ERR_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
		(have_r && err_r) |=> o_error)
		else $error("error byte without error output");

	AST_PAR_BYTE: assert property (@(posedge i_clk) disable iff (i_rst)
		(!ser_mode && have_r) |=> o_data == $past(byte_r))
		else $error("parallel byte not presented");
endmodule
`default_nettype wire

// >>> verilog/tso_cfg.svh
// constants of the transport stream output port: register offsets, bit positions,
// reset values and clock timing.
// assumes a 50 MHz master clock and a byte-wide register port inside the device.
`ifndef TSO_CFG_SVH
`define TSO_CFG_SVH

// register offsets
`define TSO_ADDR_MCLK_CFG   8'h02
`define TSO_ADDR_VIT_STAT   8'h1b
`define TSO_ADDR_FEC_MODE   8'h28
`define TSO_ADDR_DEC_CTRL   8'h33

// reset values
`define TSO_RST_MCLK_CFG    8'h34
`define TSO_RST_FEC_MODE    8'h00
`define TSO_RST_DEC_CTRL    8'h00
`define TSO_RST_SYNC_CNT    8'h00

// bit positions
`define TSO_BIT_SER_SRC     3
`define TSO_BIT_OUT_IMP     0
`define TSO_BIT_OUT_SER     1
`define TSO_BIT_PAR_BLANK   5
`define TSO_BIT_EDGE_SEL    1
`define TSO_BIT_LOCK        3

// half periods of the output clock in master clock cycles; last serial bit, fifo depth and fifo word width
`define TSO_HALF_MCLK       2'h1
`define TSO_HALF_VCO        2'h2
`define TSO_LAST_BIT        3'h7
`define TSO_FIFO_DEPTH      4
`define TSO_WORD_W          11

`endif

// >>> verilog/tso_pkg.sv
// types shared by the transport stream output port.
// assumes tso_cfg.svh supplies the numeric constants.
package tso_pkg;
	typedef logic [7:0] tso_byte_t;
	typedef enum logic {
		PH_LOW,
		PH_HIGH
	} tso_phase_e;
endpackage

// >>> verilog/tso_fifo.sv
// small synchronous fifo with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset; depth a power of two.
`timescale 1ns/10ps
`default_nettype none
module tso_fifo #(
	parameter int W = 11,
	parameter int D = 4
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_wdata,
	input  wire logic         i_wvalid,
	output logic              o_wready,
	output logic [W-1:0]      o_rdata,
	output logic              o_rvalid,
	input  wire logic         i_rready
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_r [D];
	logic [AW:0]   wptr_r;
	logic [AW:0]   rptr_r;
	logic          push;
	logic          pop;

	// full when pointers differ only in the wrap bit
	assign o_wready = !((wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]));
	assign o_rvalid = (wptr_r != rptr_r);
	assign o_rdata  = mem_r[rptr_r[AW-1:0]];
	assign push     = i_wvalid && o_wready;
	assign pop      = o_rvalid && i_rready;

	// storage, no reset needed since empty entries are never read
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[wptr_r[AW-1:0]] <= i_wdata;
		end
	end

	// pointers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= rptr_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/tso_rx_model.sv
// downstream receiver model: samples the stream pins on the rising output clock.
// assumes edge select 0 and pins that change on master clock edges.
`timescale 1ns/10ps
`default_nettype none
module tso_rx_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_serial,
	input  wire logic [7:0] i_data,
	input  wire logic       i_clk_out,
	input  wire logic       i_strobe,
	input  wire logic       i_valid,
	input  wire logic       i_error
);
	logic [7:0] got_r [0:15];
	logic [7:0] sh_r;
	logic [3:0] n_r;
	logic [3:0] pkt_r;
	logic [3:0] err_r;
	logic [2:0] bit_r;
	logic [2:0] hi_r;
	logic [2:0] hlen_r;
	logic       prev_r;
	logic       lo_r;
	// edge detect on the master clock; the output clock is slower, so no edge is missed
	always_ff @(posedge i_clk) begin
		prev_r <= i_clk_out;
		hi_r <= i_clk_out ? hi_r + 3'h1 : 3'h0;
		if (!i_clk_out && prev_r)
			hlen_r <= hi_r; // high time of the last clock pulse
		if (i_serial && (i_data[6:0] != 7'h00))
			lo_r <= 1'b1;
		if (i_rst) begin
			n_r <= 4'h0;
			pkt_r <= 4'h0;
			err_r <= 4'h0;
			bit_r <= 3'h0;
			lo_r <= 1'b0;
		end else if (i_clk_out && !prev_r && i_valid) begin
			if (i_strobe && !i_error)
				pkt_r <= pkt_r + 4'h1;
			if (i_error)
				err_r <= err_r + 4'h1;
			sh_r <= {sh_r[6:0], i_data[7]};
			bit_r <= i_strobe ? 3'h1 : bit_r + 3'h1;
			// serial bytes complete on the eighth bit after a strobe
			if (!i_serial || bit_r == 3'h7) begin
				got_r[n_r] <= i_serial ? {sh_r[6:0], i_data[7]} : i_data;
				n_r <= n_r + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/transport_stream_output_port_tb_top.sv
// self-checking bench of the transport stream output port.
// assumes tso_out_port and tso_rx_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module transport_stream_output_port_tb_top;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic [7:0] byte_d = 8'h00;
	logic       bv = 1'b0;
	logic       bs = 1'b0;
	logic       be = 1'b0;
	logic       bp = 1'b0;
	logic       sf = 1'b0;
	logic       sm = 1'b0;
	logic [7:0] smax = 8'h02;
	logic       ser = 1'b0;
	logic       full = 1'b0;
	logic [7:0] rdata;
	logic [7:0] data;
	logic       bready;
	logic       clko;
	logic       strb;
	logic       vld;
	logic       err;
	logic       oe;
	logic       esel;
	int         err_total = 0;
	int         compares = 0;
	// 50 MHz master clock
	always #10 clk = ~clk;
	tso_out_port u_dut (
		.i_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .o_reg_rdata(rdata), .i_byte(byte_d), .i_byte_valid(bv),
		.i_byte_start(bs), .i_byte_err(be), .i_byte_parity(bp), .o_byte_ready(bready),
		.i_sync_found(sf), .i_sync_missed(sm), .i_sync_max(smax), .o_data(data),
		.o_clk_out(clko), .o_strobe(strb), .o_valid(vld), .o_error(err), .o_oe(oe),
		.o_edge_sel(esel)
	);
	tso_rx_model u_rx (
		.i_clk(clk), .i_rst(rst), .i_serial(ser), .i_data(data), .i_clk_out(clko),
		.i_strobe(strb), .i_valid(vld), .i_error(err)
	);
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic reset_all();
		rst <= 1'b1;
		ser <= 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		repeat (2) @(posedge clk);
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask
	// valid held across back-to-back bytes; ready looked at once settled
	task automatic send(input logic [7:0] b, input logic s, input logic e, input logic p);
		int n;
		byte_d <= b;
		bs <= s;
		be <= e;
		bp <= p;
		bv <= 1'b1;
		for (n = 0; n < 300; n++) begin
			@(negedge clk);
			if (bready === 1'b1)
				break;
			full = 1'b1;
		end
		if (n == 300)
			err_total++;
		@(posedge clk);
	endtask
	task automatic pkt(input logic [7:0] base, input int len, input logic e, input logic p);
		for (int i = 0; i < len; i++)
			send(base + 8'(i), i == 0, e, p && (i == len - 1));
		bv <= 1'b0;
	endtask
	task automatic pulse_sync(input logic found, input int n);
		repeat (n) begin
			sf <= found;
			sm <= !found;
			@(posedge clk);
			sf <= 1'b0;
			sm <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic wait_rx(input logic [3:0] want);
		for (int i = 0; i < 600 && u_rx.n_r !== want; i++)
			@(posedge clk);
		chk("rx_count", u_rx.n_r, want);
	endtask
	task automatic t_regs();
		logic [7:0] d;
		reset_all();
		rd_reg(8'h02, d);
		chk("mclk_cfg", d, 8'h34);
		rd_reg(8'h28, d);
		chk("fec_mode", d, 8'h00);
		rd_reg(8'h33, d);
		chk("dec_ctrl", d, 8'h00);
		rd_reg(8'h1b, d);
		chk("status", d, 8'h00);
		wr_reg(8'h40, 8'hff);
		rd_reg(8'h40, d);
		chk("unmapped", d, 8'h00);
		chk("oe_reset", oe, 1'b1);
		chk("edge_reset", esel, 1'b0);
		wr_reg(8'h28, 8'h01);
		wr_reg(8'h33, 8'h02);
		@(negedge clk);
		chk("oe_float", oe, 1'b0);
		chk("edge_sel", esel, 1'b1);
		$display("test regs done");
	endtask
	task automatic t_nolock();
		logic bad;
		bad = 1'b0;
		reset_all();
		pkt(8'h10, 3, 1'b0, 1'b0);
		repeat (40) begin
			@(negedge clk);
			bad = bad | (vld !== 1'b0);
		end
		chk("valid_unlocked", bad, 1'b0);
		$display("test nolock done");
	endtask
	task automatic t_par();
		logic [7:0] d;
		reset_all();
		pulse_sync(1'b1, 1);
		rd_reg(8'h1b, d);
		chk("lock_below_max", d, 8'h00);
		pulse_sync(1'b1, 2);
		rd_reg(8'h1b, d);
		chk("lock_at_max", d, 8'h08);
		pkt(8'h47, 4, 1'b0, 1'b0);
		wait_rx(4'h4);
		for (int i = 0; i < 4; i++)
			chk("par_byte", u_rx.got_r[i], 8'h47 + 8'(i));
		chk("par_starts", u_rx.pkt_r, 8'h01);
		pulse_sync(1'b0, 1);
		rd_reg(8'h1b, d);
		chk("lock_held", d, 8'h08);
		pulse_sync(1'b0, 1);
		rd_reg(8'h1b, d);
		chk("lock_cleared", d, 8'h00);
		$display("test parallel done");
	endtask
	task automatic t_ser();
		reset_all();
		wr_reg(8'h28, 8'h02);
		ser <= 1'b1;
		pulse_sync(1'b1, 2);
		full = 1'b0;
		pkt(8'hb4, 6, 1'b0, 1'b0);
		chk("fifo_refused", full, 1'b1);
		wait_rx(4'h6);
		for (int i = 0; i < 6; i++)
			chk("ser_byte", u_rx.got_r[i], 8'hb4 + 8'(i));
		chk("ser_starts", u_rx.pkt_r, 8'h01);
		chk("low_lines", u_rx.lo_r, 1'b0);
		$display("test serial done");
	endtask
	task automatic t_err();
		reset_all();
		pulse_sync(1'b1, 2);
		pkt(8'h20, 3, 1'b1, 1'b0);
		wait_rx(4'h3);
		chk("err_bytes", u_rx.err_r, 8'h03);
		chk("err_starts", u_rx.pkt_r, 8'h00);
		// a one-byte flagged packet in serial format: one error count per bit
		wr_reg(8'h28, 8'h02);
		ser <= 1'b1;
		pkt(8'h30, 1, 1'b1, 1'b0);
		wait_rx(4'h4);
		chk("err_serial", u_rx.err_r, 8'h0b);
		$display("test error done");
	endtask
	task automatic t_blank();
		reset_all();
		pulse_sync(1'b1, 2);
		// blanking applies to the serial stream; let the first packet drain first
		wr_reg(8'h28, 8'h02);
		ser <= 1'b1;
		pkt(8'h5a, 2, 1'b0, 1'b1);
		wait_rx(4'h2);
		chk("parity_sent", u_rx.got_r[1], 8'h5b);
		wr_reg(8'h33, 8'h20);
		pkt(8'h5a, 2, 1'b0, 1'b1);
		wait_rx(4'h4);
		chk("data_kept", u_rx.got_r[2], 8'h5a);
		chk("parity_blank", u_rx.got_r[3], 8'h00);
		$display("test blank done");
	endtask
	task automatic t_slow();
		reset_all();
		wr_reg(8'h02, 8'h3c);
		pulse_sync(1'b1, 2);
		pkt(8'h81, 2, 1'b0, 1'b0);
		wait_rx(4'h2);
		chk("slow_byte", u_rx.got_r[1], 8'h82);
		chk("slow_high", u_rx.hlen_r, 8'h02);
		$display("test slow clock done");
	endtask
	// a hang ends the run through the same closing task
	initial begin
		#(20 * 20000);
		err_total++;
		test_done();
	end
	initial begin
		t_regs();
		t_nolock();
		t_par();
		t_ser();
		t_err();
		t_blank();
		t_slow();
		test_done();
	end
endmodule
`default_nettype wire
